// ### rtl/wdc_pkg.sv
// Package: timing constants and enumerations for the wide DRAM controller
package wdc_pkg;
    localparam int unsigned CLK_MHZ            = 25;
    localparam int unsigned CLK_PERIOD_NS      = 40;
    localparam int unsigned POWERUP_PAUSE_US   = 100;
    localparam int unsigned POWERUP_PAUSE_CYC  = POWERUP_PAUSE_US * CLK_MHZ;
    localparam int unsigned WAKE_CYCLES        = 8;
    localparam int unsigned REFRESH_INTERVAL_MS = 128;
    localparam int unsigned REFRESH_ROWS       = 1024;
    localparam int unsigned REFRESH_INTERVAL_CYC = REFRESH_INTERVAL_MS * 1000 * CLK_MHZ;
    localparam int unsigned REFRESH_SPACING_CYC  = REFRESH_INTERVAL_CYC / REFRESH_ROWS;
    localparam int unsigned SELF_REFRESH_ENTRY_US = 100;
    localparam int unsigned SELF_REFRESH_ENTRY_CYC = SELF_REFRESH_ENTRY_US * CLK_MHZ;
    localparam int unsigned SELF_REFRESH_EXIT_NS = 150;
    localparam int unsigned SELF_REFRESH_EXIT_CYC = (SELF_REFRESH_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ROW_PRECHARGE_NS   = 60;
    localparam int unsigned ROW_PRECHARGE_CYC  = (ROW_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ROW_ACTIVE_NS      = 80;
    localparam int unsigned ROW_ACTIVE_CYC     = (ROW_ACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned OUTPUT_TURNOFF_NS  = 15;
    localparam int unsigned OUTPUT_TURNOFF_CYC = (OUTPUT_TURNOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned COLUMN_PRECHARGE_MIN_NS = 10;
    localparam int unsigned COLUMN_PRECHARGE_MIN_CYC =
        (COLUMN_PRECHARGE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W              = 24;

    typedef enum logic [1:0] {
        WDC_OP_READ,
        WDC_OP_WRITE,
        WDC_OP_RMW
    } wdc_op_e;

    typedef enum {
        WDC_PAUSE,
        WDC_WAKE_CAS,
        WDC_WAKE_RAS,
        WDC_WAKE_PRE,
        WDC_IDLE,
        WDC_ROW,
        WDC_COL,
        WDC_RD_DONE,
        WDC_TURN,
        WDC_WR,
        WDC_PRE,
        WDC_REF_CAS,
        WDC_REF_RAS,
        WDC_SELF,
        WDC_SELF_EXIT
    } wdc_state_e;
endpackage

// ### rtl/wdc_ctrl.sv
// Host-side strobe sequencer for an asynchronous 1M x 8 wide DRAM
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Pause, then eight wake refresh cycles
// - Repeat wake-up when refresh interval exceeded (not done; only periodic CBR and post-self-refresh burst)
// - Column strobe pulsed high before each cycle
// - Output enable held high for late writes
// - Hidden refresh after write keeps strobes (not done; refresh is CBR from idle only)
// - Output enable high during late writes
// - Refresh all rows after self-refresh exit
// - Burst refresh after exit precharge time
// - Write strobe at row fall selects mask
// - No write data until turn-off delay
// - Refresh all rows within refresh interval
// - Hold row strobe long for self-refresh
module wdc_ctrl #(
    parameter int unsigned PAUSE_CYC   = wdc_pkg::POWERUP_PAUSE_CYC,
    parameter int unsigned REF_SPACING = wdc_pkg::REFRESH_SPACING_CYC,
    parameter int unsigned SELF_CYC    = wdc_pkg::SELF_REFRESH_ENTRY_CYC,
    parameter int unsigned ROWS        = wdc_pkg::REFRESH_ROWS,
    parameter int unsigned ADDR_W      = 10,
    parameter int unsigned DATA_W      = 8
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire wdc_pkg::wdc_op_e  req_op,
    input  wire logic              req_masked,
    input  wire logic [DATA_W-1:0] req_mask,
    input  wire logic [ADDR_W-1:0] req_row,
    input  wire logic [ADDR_W-1:0] req_col,
    input  wire logic [DATA_W-1:0] req_wdata,
    output logic [DATA_W-1:0]      rsp_rdata,
    output logic                   rsp_valid,
    input  wire logic              self_refresh_req,
    output logic                   init_done,
    output logic                   ras_n,
    output logic                   cas_n,
    output logic                   we_n,
    output logic                   oe_n,
    output logic [ADDR_W-1:0]      addr,
    input  wire logic [DATA_W-1:0] dq_in,
    output logic [DATA_W-1:0]      dq_out,
    output logic                   dq_oe
);
    // ==========================================================
    // State
    // ==========================================================
    wdc_pkg::wdc_state_e state_reg, state_next;
    logic [wdc_pkg::CNT_W-1:0] cnt_reg, cnt_next;
    logic [wdc_pkg::CNT_W-1:0] ref_tmr_reg, ref_tmr_next;
    logic [ADDR_W:0]           burst_reg, burst_next;
    logic                      ref_due_reg, ref_due_next;
    logic                      init_reg, init_next;
    wdc_pkg::wdc_op_e          op_reg, op_next;
    logic [ADDR_W-1:0]         col_reg, col_next;
    logic [DATA_W-1:0]         wd_reg, wd_next, rd_reg, rd_next;
    logic                      rv_reg, rv_next;
    logic ras_next, cas_next, we_next, oe_next, dqoe_next;
    logic [ADDR_W-1:0] addr_next;
    logic [DATA_W-1:0] dqo_next;
    function automatic logic [wdc_pkg::CNT_W-1:0] cyc(input int unsigned n);
        cyc = wdc_pkg::CNT_W'((n > 0) ? n - 1 : 0);
    endfunction
    assign req_ready = (state_reg == wdc_pkg::WDC_IDLE) && !ref_due_reg && !self_refresh_req;
    assign init_done = init_reg;
    assign rsp_rdata = rd_reg;
    assign rsp_valid = rv_reg;
    always_comb begin
        state_next   = state_reg;
        cnt_next     = (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
        ref_tmr_next = ref_tmr_reg;
        burst_next   = burst_reg;
        ref_due_next = ref_due_reg;
        init_next    = init_reg;
        op_next      = op_reg;
        col_next     = col_reg;
        wd_next      = wd_reg;
        rd_next      = rd_reg;
        rv_next      = 1'b0;
        ras_next     = ras_n;
        cas_next     = cas_n;
        we_next      = we_n;
        oe_next      = oe_n;
        addr_next    = addr;
        dqo_next     = dq_out;
        dqoe_next    = dq_oe;
        unique case (state_reg)
            wdc_pkg::WDC_PAUSE: begin
                if (cnt_reg == '0) begin
                    burst_next = (ADDR_W+1)'(wdc_pkg::WAKE_CYCLES);
                    state_next = wdc_pkg::WDC_WAKE_CAS;
                end
            end
            wdc_pkg::WDC_WAKE_CAS, wdc_pkg::WDC_REF_CAS: begin
                cas_next   = 1'b0;
                state_next = (state_reg == wdc_pkg::WDC_WAKE_CAS) ? wdc_pkg::WDC_WAKE_RAS : wdc_pkg::WDC_REF_RAS;
            end
            wdc_pkg::WDC_WAKE_RAS: begin
                ras_next   = 1'b0;
                cnt_next   = cyc(wdc_pkg::ROW_ACTIVE_CYC);
                state_next = wdc_pkg::WDC_WAKE_PRE;
            end
            wdc_pkg::WDC_WAKE_PRE: begin
                if (cnt_reg == '0 && !ras_n) begin
                    ras_next   = 1'b1;
                    cas_next   = 1'b1;
                    burst_next = burst_reg - 1'b1;
                    cnt_next   = cyc(wdc_pkg::ROW_PRECHARGE_CYC);
                end else if (cnt_reg == '0 && ras_n) begin
                    // eight wake, ROWS burst or one periodic refresh cycle
                    if (burst_reg == '0) begin
                        init_next    = 1'b1;
                        ref_due_next = ref_due_reg && init_reg;
                        ref_tmr_next = cyc(REF_SPACING);
                        state_next   = wdc_pkg::WDC_IDLE;
                    end else begin
                        state_next = wdc_pkg::WDC_WAKE_CAS;
                    end
                end
            end
            wdc_pkg::WDC_IDLE: begin
                if (ref_due_reg || self_refresh_req) begin
                    ref_due_next = 1'b0;
                    state_next   = wdc_pkg::WDC_REF_CAS;
                end else if (req_valid) begin
                    op_next    = req_op;
                    col_next   = req_col;
                    wd_next    = req_wdata;
                    addr_next  = req_row;
                    // write strobe and mask at row fall
                    we_next    = !(req_masked && req_op != wdc_pkg::WDC_OP_READ);
                    dqo_next   = req_mask;
                    dqoe_next  = req_masked && req_op != wdc_pkg::WDC_OP_READ;
                    state_next = wdc_pkg::WDC_ROW;
                end
            end
            wdc_pkg::WDC_ROW: begin
                ras_next   = 1'b0;
                state_next = wdc_pkg::WDC_COL;
            end
            wdc_pkg::WDC_COL: begin
                addr_next  = col_reg;
                cas_next   = 1'b0;
                we_next    = 1'b1;
                oe_next    = 1'b0;
                dqoe_next  = 1'b0;
                cnt_next   = cyc(wdc_pkg::ROW_ACTIVE_CYC);
                state_next = wdc_pkg::WDC_RD_DONE;
                if (op_reg == wdc_pkg::WDC_OP_WRITE) begin
                    // early write, strobe low with column strobe fall
                    we_next   = 1'b0;
                    oe_next   = 1'b1;
                    dqo_next  = wd_reg;
                    dqoe_next = 1'b1;
                end
            end
            wdc_pkg::WDC_RD_DONE: begin
                if (cnt_reg == '0) begin
                    rd_next    = (op_reg == wdc_pkg::WDC_OP_WRITE) ? rd_reg : dq_in;
                    rv_next    = (op_reg == wdc_pkg::WDC_OP_READ);
                    state_next = wdc_pkg::WDC_PRE;
                    if (op_reg == wdc_pkg::WDC_OP_RMW) begin
                        oe_next    = 1'b1;
                        cnt_next   = cyc(wdc_pkg::OUTPUT_TURNOFF_CYC);
                        state_next = wdc_pkg::WDC_TURN;
                    end
                end
            end
            // wait turn-off before driving write data
            wdc_pkg::WDC_TURN: begin
                if (cnt_reg == '0) begin
                    dqo_next   = wd_reg;
                    dqoe_next  = 1'b1;
                    state_next = wdc_pkg::WDC_WR;
                end
            end
            wdc_pkg::WDC_WR: begin
                we_next    = 1'b0;
                cnt_next   = cyc(wdc_pkg::ROW_ACTIVE_CYC);
                state_next = wdc_pkg::WDC_PRE;
                rv_next    = 1'b1;
            end
            // column strobe returns high before next cycle
            wdc_pkg::WDC_PRE: begin
                if (cnt_reg == '0 && !ras_n) begin
                    ras_next  = 1'b1;
                    cas_next  = 1'b1;
                    we_next   = 1'b1;
                    oe_next   = 1'b1;
                    dqoe_next = 1'b0;
                    cnt_next  = cyc(wdc_pkg::ROW_PRECHARGE_CYC);
                end else if (cnt_reg == '0) begin
                    state_next = wdc_pkg::WDC_IDLE;
                end
            end
            wdc_pkg::WDC_REF_RAS: begin
                ras_next = 1'b0;
                if (self_refresh_req) begin
                    cnt_next   = cyc(SELF_CYC);
                    state_next = wdc_pkg::WDC_SELF;
                end else begin
                    cnt_next   = cyc(wdc_pkg::ROW_ACTIVE_CYC);
                    burst_next = (ADDR_W+1)'(1);
                    state_next = wdc_pkg::WDC_WAKE_PRE;
                end
            end
            // row strobe held low for self-refresh entry
            wdc_pkg::WDC_SELF: begin
                if (cnt_reg == '0 && !self_refresh_req) begin
                    ras_next   = 1'b1;
                    cas_next   = 1'b1;
                    cnt_next   = cyc(wdc_pkg::SELF_REFRESH_EXIT_CYC);
                    state_next = wdc_pkg::WDC_SELF_EXIT;
                end
            end
            wdc_pkg::WDC_SELF_EXIT: begin
                if (cnt_reg == '0) begin
                    burst_next = (ADDR_W+1)'(ROWS);
                    init_next  = 1'b0;
                    state_next = wdc_pkg::WDC_WAKE_CAS;
                end
            end
        endcase
        if (state_reg != wdc_pkg::WDC_SELF && init_reg) begin
            if (ref_tmr_reg == '0) begin
                ref_tmr_next = cyc(REF_SPACING);
                ref_due_next = 1'b1;
            end else begin
                ref_tmr_next = ref_tmr_reg - 1'b1;
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg   <= wdc_pkg::WDC_PAUSE;
            cnt_reg     <= cyc(PAUSE_CYC);
            ref_tmr_reg <= '0;
            burst_reg   <= '0;
            ref_due_reg <= 1'b0;
            init_reg    <= 1'b0;
            op_reg      <= wdc_pkg::WDC_OP_READ;
            col_reg     <= '0;
            wd_reg      <= '0;
            rd_reg      <= '0;
            rv_reg      <= 1'b0;
            ras_n       <= 1'b1;
            cas_n       <= 1'b1;
            we_n        <= 1'b1;
            oe_n        <= 1'b1;
            addr        <= '0;
            dq_out      <= '0;
            dq_oe       <= 1'b0;
        end else begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            ref_tmr_reg <= ref_tmr_next;
            burst_reg   <= burst_next;
            ref_due_reg <= ref_due_next;
            init_reg    <= init_next;
            op_reg      <= op_next;
            col_reg     <= col_next;
            wd_reg      <= wd_next;
            rd_reg      <= rd_next;
            rv_reg      <= rv_next;
            ras_n       <= ras_next;
            cas_n       <= cas_next;
            we_n        <= we_next;
            oe_n        <= oe_next;
            addr        <= addr_next;
            dq_out      <= dqo_next;
            dq_oe       <= dqoe_next;
        end
    end
endmodule
`default_nettype wire

// ### testbench/wdc_ctrl_monitor.sv
// Port checker for the wide DRAM controller
`timescale 1ns/1ps
`default_nettype none
module wdc_ctrl_monitor #(
    parameter int unsigned PAUSE_CYC   = 20,
    parameter int unsigned REF_SPACING = 50,
    parameter int unsigned SELF_CYC    = 10,
    parameter int unsigned ROWS        = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req_ready,
    input wire logic self_refresh_req,
    input wire logic init_done,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic dq_oe
);
    int unsigned cyc;
    int unsigned ras_lo;
    int unsigned cbr_cnt;
    int unsigned gap;
    int unsigned sr_cnt;
    logic        ras_q;
    logic        after_self;
    logic        cbr_fall;
    assign cbr_fall = ras_q && !ras_n && !cas_n;
    // ==========
    // Helper counters
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cyc <= 0;
            ras_lo <= 0;
            cbr_cnt <= 0;
            gap <= 0;
            sr_cnt <= 0;
            ras_q <= 1'b1;
            after_self <= 1'b0;
        end else begin
            ras_q <= ras_n;
            cyc <= (cyc > PAUSE_CYC) ? cyc : cyc + 1;
            ras_lo <= ras_n ? 0 : ras_lo + 1;
            cbr_cnt <= init_done ? 0 : cbr_cnt + (cbr_fall ? 1 : 0);
            // Long row-low spans are self-refresh, which also counts as refreshing
            gap <= (!init_done || cbr_fall || ras_lo > 6) ? 0 : gap + 1;
            sr_cnt <= !self_refresh_req ? 0 : (sr_cnt > 50) ? sr_cnt : sr_cnt + 1;
            if (ras_n && ras_lo >= SELF_CYC) after_self <= 1'b1;
        end
    end
    // ==========
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence row_open; $fell(ras_n) && cas_n; endsequence
    sequence self_end; $rose(ras_n) && ras_lo >= SELF_CYC; endsequence
    pause_first_a: assert property ($fell(ras_n) && cbr_cnt == 0 && !after_self |-> cyc >= PAUSE_CYC)
        else $error("row strobe before power-up pause");
    wake_count_a: assert property ($rose(init_done) |-> cbr_cnt >= (after_self ? ROWS : 8))
        else $error("too few refresh cycles before ready");
    ready_init_a: assert property (req_ready |-> init_done)
        else $error("request accepted before wake-up");
    refresh_gap_a: assert property (gap <= REF_SPACING + 16)
        else $error("refresh spacing exceeded");
    cas_precharge_a: assert property (row_open |-> $past(cas_n))
        else $error("column strobe not precharged before row");
    mask_at_row_a: assert property (row_open |-> dq_oe == !we_n)
        else $error("mask drive does not match write type");
    drive_oe_off_a: assert property (dq_oe |-> oe_n)
        else $error("data driven while outputs enabled");
    turn_delay_a: assert property ($rose(dq_oe) && !cas_n |-> $past(oe_n))
        else $error("write data driven before turn-off delay");
    write_oe_high_a: assert property (!we_n && !cas_n && !ras_n |-> oe_n)
        else $error("output enable low during write");
    self_hold_a: assert property (sr_cnt == 40 |-> !ras_n && !cas_n)
        else $error("self-refresh not held");
    self_exit_a: assert property (self_end |-> ras_n[*4])
        else $error("exit precharge too short");
endmodule
`default_nettype wire

// ### testbench/wdc_dram_model.sv
// Behavioural wide DRAM answering the controller's strobes
`timescale 1ns/1ps
`default_nettype none
module wdc_dram_model #(
    parameter int unsigned ROWS     = 4,
    parameter int unsigned SELF_CYC = 10
) (
    input  wire logic       clk,
    input  wire logic       ras_n,
    input  wire logic       cas_n,
    input  wire logic       we_n,
    input  wire logic       oe_n,
    input  wire logic [9:0] addr,
    input  wire logic [7:0] dq_out,
    input  wire logic       dq_oe,
    output logic [7:0]      dq_in = 8'h00,
    output int              n_cbr = 0,
    output logic            self_active = 1'b0
);
    logic [7:0] mem [0:255];
    logic [7:0] mask_q = 8'hFF;
    logic [3:0] row = 4'h0;
    logic [3:0] col = 4'h0;
    logic [3:0] ca;
    logic       ras_q = 1'b1;
    logic       cas_q = 1'b1;
    logic       we_q = 1'b1;
    logic       column_before_row_refresh = 1'b0;
    logic       is_cbr;
    int         rctr = 0;
    int         lo = 0;
    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] d);
        return (old & ~mask_q) | (d & mask_q);
    endfunction
    always @(posedge clk) begin
        is_cbr = (ras_q && !ras_n) ? !cas_n : column_before_row_refresh;
        ca = cas_q ? addr[3:0] : col;
        ras_q <= ras_n;
        cas_q <= cas_n;
        we_q <= we_n;
        if (ras_q && !ras_n) begin
            column_before_row_refresh <= !cas_n;
            if (!cas_n) n_cbr <= n_cbr + 1;
            if (!cas_n) rctr <= (rctr + 1) % ROWS;
            row <= addr[3:0];
            mask_q <= (!we_n && dq_oe) ? dq_out : 8'hFF;
        end
        if (!ras_n && cas_q && !cas_n) col <= addr[3:0];
        if (!ras_n && cas_q && !cas_n && !we_n) mem[{row, ca}] <= merge(mem[{row, ca}], dq_out);
        if (!ras_n && !cas_q && !cas_n && we_q && !we_n && !is_cbr) mem[{row, col}] <= merge(mem[{row, col}], dq_out);
        if (!ras_n && !cas_n && we_n && !oe_n && !is_cbr) dq_in <= mem[{row, ca}];
        else dq_in <= ~dq_in;
        lo <= (!ras_n && is_cbr) ? lo + 1 : 0;
        self_active <= !ras_n && is_cbr && lo >= SELF_CYC;
    end
endmodule
`default_nettype wire

// ### testbench/wdc_ctrl_bench.sv
// Self-checking bench for the wide DRAM controller
`timescale 1ns/1ps
`default_nettype none
module wdc_ctrl_bench;
    localparam int unsigned PAUSE = 20;
    localparam int unsigned REF = 50;
    localparam int unsigned SELF = 10;
    localparam int unsigned ROWS = 4;
    logic clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_masked = 1'b0, self_refresh_req = 1'b0;
    logic [7:0] req_mask = 8'h00, req_wdata = 8'h00, rsp_rdata, dq_in, dq_out, rd;
    logic [9:0] req_row = 10'h000, req_col = 10'h000, addr;
    logic req_ready, rsp_valid, init_done, ras_n, cas_n, we_n, oe_n, dq_oe, self_active;
    wdc_pkg::wdc_op_e req_op = wdc_pkg::WDC_OP_READ;
    int n_cbr, n0, n_fail = 0, checks = 0;
    always #20 clk = ~clk;
    wdc_ctrl #(.PAUSE_CYC(PAUSE), .REF_SPACING(REF), .SELF_CYC(SELF), .ROWS(ROWS)) dut (
        .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
        .req_masked(req_masked), .req_mask(req_mask), .req_row(req_row), .req_col(req_col),
        .req_wdata(req_wdata), .rsp_rdata(rsp_rdata), .rsp_valid(rsp_valid),
        .self_refresh_req(self_refresh_req), .init_done(init_done), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .oe_n(oe_n), .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
    wdc_dram_model #(.ROWS(ROWS), .SELF_CYC(SELF)) dram (.clk(clk), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .oe_n(oe_n), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in),
        .n_cbr(n_cbr), .self_active(self_active));
    // ==========
    // Shared tasks
    task automatic complete_run;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic tick;
        @(posedge clk);
        #2;
    endtask
    task automatic give_up(input string what);
        n_fail++;
        $display("mismatch %0t timeout %s", $time, what);
        complete_run();
    endtask
    // Op code 0 read, 1 write, 2 read-modify-write
    task automatic issue(input logic [1:0] op, input logic [9:0] r, input logic [7:0] d,
                         input logic m, input logic [7:0] mk);
        int i;
        req_op = wdc_pkg::wdc_op_e'(op);
        req_row = r;
        req_col = r + 10'h001;
        req_wdata = d;
        req_masked = m;
        req_mask = mk;
        req_valid = 1'b1;
        for (i = 0; i < 300 && req_ready !== 1'b1; i++) tick();
        if (i == 300) give_up("ready");
        tick();
        req_valid = 1'b0;
        tick();
        for (i = 0; i < 40 && op != 2'd1 && rsp_valid !== 1'b1; i++) tick();
        if (i == 40) give_up("response");
        rd = rsp_rdata;
    endtask
    // ==========
    // Scenarios
    task automatic t_wake;
        int i;
        for (i = 0; i < 600 && init_done !== 1'b1; i++) tick();
        if (i == 600) give_up("wake");
        chk(8'(n_cbr >= 8), 8'h01, "wake refresh count");
    endtask
    task automatic t_write_read;
        issue(2'd1, 10'h001, 8'h5A, 1'b0, 8'h00);
        issue(2'd1, 10'h003, 8'hC3, 1'b0, 8'h0F);
        issue(2'd0, 10'h001, 8'h00, 1'b0, 8'h00);
        chk(rd, 8'h5A, "early write readback");
        issue(2'd0, 10'h003, 8'h00, 1'b0, 8'h00);
        chk(rd, 8'hC3, "unmasked write ignores mask");
    endtask
    task automatic t_rmw;
        issue(2'd2, 10'h001, 8'hA5, 1'b0, 8'h00);
        chk(rd, 8'h5A, "read part of modify");
        issue(2'd0, 10'h001, 8'h00, 1'b0, 8'h00);
        chk(rd, 8'hA5, "late write data");
    endtask
    task automatic t_masked;
        issue(2'd1, 10'h001, 8'h3C, 1'b1, 8'h0F);
        issue(2'd0, 10'h001, 8'h00, 1'b0, 8'h00);
        chk(rd, 8'hAC, "masked write merge");
        issue(2'd2, 10'h003, 8'h55, 1'b1, 8'hF0);
        chk(rd, 8'hC3, "masked modify read part");
        issue(2'd0, 10'h003, 8'h00, 1'b0, 8'h00);
        chk(rd, 8'h53, "masked late write merge");
    endtask
    task automatic t_refresh;
        n0 = n_cbr;
        repeat (3 * REF) tick();
        chk(8'(n_cbr - n0 >= 2), 8'h01, "idle refresh rate");
    endtask
    task automatic t_self;
        int i;
        self_refresh_req = 1'b1;
        for (i = 0; i < 200 && self_active !== 1'b1; i++) tick();
        if (i == 200) give_up("self entry");
        repeat (30) tick();
        n0 = n_cbr;
        self_refresh_req = 1'b0;
        for (i = 0; i < 100 && init_done !== 1'b0; i++) tick();
        for (i = 0; i < 300 && init_done !== 1'b1; i++) tick();
        if (i == 300) give_up("self exit");
        chk(8'(n_cbr - n0 >= ROWS), 8'h01, "burst after self-refresh");
        issue(2'd0, 10'h001, 8'h00, 1'b0, 8'h00);
        chk(rd, 8'hAC, "data kept in self-refresh");
    endtask
    initial begin
        repeat (12) @(posedge clk);
        #2;
        rst_n = 1'b1;
        t_wake();
        t_write_read();
        t_rmw();
        t_masked();
        t_refresh();
        t_self();
        complete_run();
    end
endmodule
bind wdc_ctrl wdc_ctrl_monitor #(.PAUSE_CYC(PAUSE_CYC), .REF_SPACING(REF_SPACING), .SELF_CYC(SELF_CYC), .ROWS(ROWS))
    mon (.clk(clk), .rst_n(rst_n), .req_ready(req_ready), .self_refresh_req(self_refresh_req),
    .init_done(init_done), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n), .dq_oe(dq_oe));
`default_nettype wire
